/* iox_top.sv */
// Purpose: serial-bus target and pin logic of a forty-pin I/O expander
// Assumes: CLK at 50 MHz, far faster than the bus clock; pins open to bench
// Notes: SDA and the alert line are open drain, driven low when enabled
//
// Functional notes
// - forty pins, five banks, each pin directional
// - serves standard and fast bus clock rates
// - three selects pick one of eight addresses
// - address byte low bit selects read
// - first byte after address is command
// - low six command bits form pointer
// - step flag advances low three pointer bits
// - long writes wrap within the group
// - stepping skips reserved positions five to seven
// - step flag clear keeps pointer fixed
// - command resets to step set, rest clear
// - acknowledge writable groups, refuse level group
// - outputs change at data byte acknowledge
// - set invert bit flips value read back
// - unmasked input change pulls alert low
// - drive enable high floats all outputs
// - reset makes every pin an input
// - level registers show pins, writes ignored
// - groups at 00h, 08h, 10h, 18h, 20h

`timescale 1ns/10ps
`default_nettype none

// ============================================================
// top
module iox_top #(
	parameter logic [3:0] ADDR_PREFIX = 4'h4 // fixed upper address bits
) (
	input wire logic CLK,
	input wire logic ARST_N,
	input wire logic RESET_N,
	input wire logic SCL_I,
	input wire logic SDA_I,
	output logic SDA_O,
	output logic SDA_OE,
	input wire logic ADDR_SELECT_0,
	input wire logic ADDR_SELECT_1,
	input wire logic ADDR_SELECT_2,
	input wire logic DRIVE_EN_N,
	input wire logic [iox_pkg::PIN_COUNT-1:0] IO_I,
	output logic [iox_pkg::PIN_COUNT-1:0] IO_O,
	output logic [iox_pkg::PIN_COUNT-1:0] IO_OE,
	output logic INT_O,
	output logic INT_OE
);
	// ============================================================
	// input synchronisation
	// the reset pin starts out asserted so that change detection only arms
	// once real pin levels have come through both stages; starting it idle
	// would show every high pin as a change just after reset
	localparam logic [iox_pkg::SYNC_W-1:0] SYNC_INIT =
		{1'b0, 1'b1, 3'h0, 1'b1, 1'b1, {iox_pkg::PIN_COUNT{1'b0}}};
	logic [iox_pkg::SYNC_W-1:0] sync_q; // synchronised bundle
	logic [iox_pkg::PIN_COUNT-1:0] io_s; // pin levels
	logic scl_s; // bus clock
	logic sda_s; // bus data
	logic [2:0] sel_s; // address straps
	logic oe_n_s; // drive enable, active low
	logic rst_pin_s; // reset pin active

	iox_sync #(
		.W(iox_pkg::SYNC_W),
		.INIT(SYNC_INIT)
	) u_sync (
		.CLK(CLK),
		.ARST_N(ARST_N),
		.D({RESET_N, DRIVE_EN_N, ADDR_SELECT_2, ADDR_SELECT_1,
			ADDR_SELECT_0, SDA_I, SCL_I, IO_I}),
		.Q(sync_q)
	);

	assign io_s = sync_q[iox_pkg::PIN_COUNT-1:0];
	assign scl_s = sync_q[iox_pkg::PIN_COUNT];
	assign sda_s = sync_q[iox_pkg::PIN_COUNT+1];
	assign sel_s = sync_q[iox_pkg::PIN_COUNT+4:iox_pkg::PIN_COUNT+2];
	assign oe_n_s = sync_q[iox_pkg::PIN_COUNT+5];
	assign rst_pin_s = ~sync_q[iox_pkg::PIN_COUNT+6];

	// ============================================================
	// helper decodes
	// bank index inside a group is a real bank
	function automatic logic bank_ok(input logic [iox_pkg::PTR_W-1:0] p);
		bank_ok = (p[2:0] <= iox_pkg::LAST_BANK);
	endfunction

	// pointer aims at a writable bank register
	function automatic logic write_ok(input logic [iox_pkg::PTR_W-1:0] p);
		write_ok = bank_ok(p) && (p[5:3] != iox_pkg::GRP_LEVEL) &&
			(p[5:3] <= iox_pkg::GRP_MASK);
	endfunction

	// ============================================================
	// bus edge detection
	logic scl_d_q; // previous bus clock
	logic sda_d_q; // previous bus data
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;

	// one more stage behind the synchroniser gives clean edges; at 50 MHz
	// a fast-rate clock phase still spans dozens of samples
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			scl_d_q <= 1'b1;
			sda_d_q <= 1'b1;
		end else begin
			scl_d_q <= scl_s;
			sda_d_q <= sda_s;
		end
	end

	assign scl_rise = scl_s & ~scl_d_q;
	assign scl_fall = ~scl_s & scl_d_q;
	assign bus_start = scl_s & scl_d_q & sda_d_q & ~sda_s;
	assign bus_stop = scl_s & scl_d_q & ~sda_d_q & sda_s;

	// ============================================================
	// target state machine
	iox_pkg::iox_state_t state_q;
	logic [7:0] shift_q; // received or outgoing byte
	logic [3:0] cnt_q; // bits moved in current byte
	logic full_q; // eight bits received
	logic rw_q; // transfer is a read
	logic mack_q; // master acknowledged last read byte
	logic sda_oe_q; // pulling SDA low
	logic [7:0] cmd_q; // command register
	logic [7:0] rd_byte; // register selected for reading
	logic [6:0] own_addr;
	logic cmd_load;
	logic wr_evt;
	logic rd_load;
	logic rd_done;
	logic step;

	assign own_addr = {ADDR_PREFIX, sel_s};
	assign cmd_load = (state_q == iox_pkg::ST_CMD) & scl_fall & full_q;
	assign wr_evt = (state_q == iox_pkg::ST_WDATA) & scl_fall & full_q &
		write_ok(cmd_q[iox_pkg::PTR_W-1:0]);
	assign rd_load = scl_fall & (((state_q == iox_pkg::ST_AACK) & rw_q) |
		((state_q == iox_pkg::ST_RACK) & mack_q));
	assign rd_done = (state_q == iox_pkg::ST_RDATA) & scl_fall &
		(cnt_q == 4'h8);
	assign step = (wr_evt | rd_done) & cmd_q[iox_pkg::STEP_BIT];

	// sampling on rise, driving on fall; reset pin and stop win over all, then start
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			state_q <= iox_pkg::ST_IDLE;
			shift_q <= 8'h00;
			cnt_q <= 4'h0;
			full_q <= 1'b0;
			rw_q <= 1'b0;
			mack_q <= 1'b0;
			sda_oe_q <= 1'b0;
		end else if (rst_pin_s || bus_stop) begin
			state_q <= iox_pkg::ST_IDLE;
			sda_oe_q <= 1'b0;
		end else if (bus_start) begin
			// repeated start also lands here
			state_q <= iox_pkg::ST_ADDR;
			cnt_q <= 4'h0;
			full_q <= 1'b0;
			sda_oe_q <= 1'b0;
		end else begin
			case (state_q)
				iox_pkg::ST_ADDR, iox_pkg::ST_CMD, iox_pkg::ST_WDATA: begin
					if (scl_rise) begin
						shift_q <= {shift_q[6:0], sda_s};
						cnt_q <= cnt_q + 4'h1;
						full_q <= (cnt_q == 4'h7);
					end else if (scl_fall && full_q) begin
						cnt_q <= 4'h0;
						full_q <= 1'b0;
						if (state_q == iox_pkg::ST_ADDR) begin
							if (shift_q[7:1] == own_addr) begin
								rw_q <= shift_q[0];
								sda_oe_q <= 1'b1;
								state_q <= iox_pkg::ST_AACK;
							end else begin
								state_q <= iox_pkg::ST_WAIT;
							end
						end else if (state_q == iox_pkg::ST_CMD) begin
							sda_oe_q <= 1'b1;
							state_q <= iox_pkg::ST_CACK;
						end else begin
							// level group and holes get no acknowledge
							sda_oe_q <= write_ok(cmd_q[5:0]);
							state_q <= iox_pkg::ST_WACK;
						end
					end
				end
				iox_pkg::ST_AACK: begin
					if (scl_fall) begin
						if (rw_q) begin
							shift_q <= rd_byte;
							sda_oe_q <= ~rd_byte[7];
							cnt_q <= 4'h1;
							state_q <= iox_pkg::ST_RDATA;
						end else begin
							sda_oe_q <= 1'b0;
							state_q <= iox_pkg::ST_CMD;
						end
					end
				end
				iox_pkg::ST_CACK, iox_pkg::ST_WACK: begin
					// release after the acknowledge clock, more data follows
					if (scl_fall) begin
						sda_oe_q <= 1'b0;
						state_q <= iox_pkg::ST_WDATA;
					end
				end
				iox_pkg::ST_RDATA: begin
					if (scl_fall) begin
						if (cnt_q == 4'h8) begin
							sda_oe_q <= 1'b0;
							state_q <= iox_pkg::ST_RACK;
						end else begin
							shift_q <= {shift_q[6:0], 1'b0};
							sda_oe_q <= ~shift_q[6];
							cnt_q <= cnt_q + 4'h1;
						end
					end
				end
				iox_pkg::ST_RACK: begin
					if (scl_rise) begin
						mack_q <= ~sda_s;
					end else if (scl_fall) begin
						if (mack_q) begin
							shift_q <= rd_byte;
							sda_oe_q <= ~rd_byte[7];
							cnt_q <= 4'h1;
							state_q <= iox_pkg::ST_RDATA;
						end else begin
							state_q <= iox_pkg::ST_WAIT;
						end
					end
				end
				iox_pkg::ST_WAIT: begin
					sda_oe_q <= 1'b0;
				end
				default: begin
					state_q <= iox_pkg::ST_IDLE;
				end
			endcase
		end
	end

	assign SDA_O = 1'b0;
	assign SDA_OE = sda_oe_q;

	// ============================================================
	// command register and pointer
	// the master is trusted to use defined codes only; a hole still
	// reads as zero and refuses writes, so nothing breaks
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			cmd_q <= iox_pkg::CMD_RESET;
		end else if (rst_pin_s) begin
			cmd_q <= iox_pkg::CMD_RESET;
		end else if (cmd_load) begin
			cmd_q <= shift_q;
		end else if (step) begin
			// only the bank bits move, so the group never changes
			if (cmd_q[2:0] >= iox_pkg::LAST_BANK) begin
				cmd_q[2:0] <= 3'h0;
			end else begin
				cmd_q[2:0] <= cmd_q[2:0] + 3'h1;
			end
		end
		// step flag clear: pointer held as is
	end

	// ============================================================
	// bank registers
	logic [7:0] drive_value_regs [iox_pkg::NUM_BANKS];
	logic [7:0] invert_regs [iox_pkg::NUM_BANKS];
	logic [7:0] direction_regs [iox_pkg::NUM_BANKS];
	logic [7:0] alert_mask_regs [iox_pkg::NUM_BANKS];
	logic [iox_pkg::PIN_COUNT-1:0] drive_flat;
	logic [iox_pkg::PIN_COUNT-1:0] inv_flat;
	logic [iox_pkg::PIN_COUNT-1:0] dir_flat; // one means input
	logic [iox_pkg::PIN_COUNT-1:0] mask_flat;
	logic [iox_pkg::PIN_COUNT-1:0] level_flat; // pins after inversion

	// written at the fall that opens the acknowledge clock
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			for (int b = 0; b < iox_pkg::NUM_BANKS; b++) begin
				drive_value_regs[b] <= iox_pkg::DRIVE_RESET;
				invert_regs[b] <= iox_pkg::INVERT_RESET;
				direction_regs[b] <= iox_pkg::DIR_RESET;
				alert_mask_regs[b] <= iox_pkg::MASK_RESET;
			end
		end else if (rst_pin_s) begin
			for (int b = 0; b < iox_pkg::NUM_BANKS; b++) begin
				drive_value_regs[b] <= iox_pkg::DRIVE_RESET;
				invert_regs[b] <= iox_pkg::INVERT_RESET;
				direction_regs[b] <= iox_pkg::DIR_RESET;
				alert_mask_regs[b] <= iox_pkg::MASK_RESET;
			end
		end else if (wr_evt) begin
			case (cmd_q[5:3])
				iox_pkg::GRP_DRIVE: drive_value_regs[cmd_q[2:0]] <= shift_q;
				iox_pkg::GRP_INVERT: invert_regs[cmd_q[2:0]] <= shift_q;
				iox_pkg::GRP_DIR: direction_regs[cmd_q[2:0]] <= shift_q;
				iox_pkg::GRP_MASK: alert_mask_regs[cmd_q[2:0]] <= shift_q;
				default: begin
					// level group is never written
				end
			endcase
		end
	end

	// flatten per-bank registers onto pin vectors
	for (genvar b = 0; b < iox_pkg::NUM_BANKS; b++) begin : g_bank
		assign drive_flat[b*iox_pkg::BANK_W +: iox_pkg::BANK_W] =
			drive_value_regs[b];
		assign inv_flat[b*iox_pkg::BANK_W +: iox_pkg::BANK_W] = invert_regs[b];
		assign dir_flat[b*iox_pkg::BANK_W +: iox_pkg::BANK_W] =
			direction_regs[b];
		assign mask_flat[b*iox_pkg::BANK_W +: iox_pkg::BANK_W] =
			alert_mask_regs[b];
	end

	// levels read back whatever the direction
	assign level_flat = io_s ^ inv_flat;

	// read selection; holes and unknown groups read zero
	always_comb begin
		rd_byte = 8'h00;
		if (bank_ok(cmd_q[5:0])) begin
			case (cmd_q[5:3])
				iox_pkg::GRP_LEVEL: rd_byte = level_flat[{cmd_q[2:0], 3'h0} +: 8];
				iox_pkg::GRP_DRIVE: rd_byte = drive_value_regs[cmd_q[2:0]];
				iox_pkg::GRP_INVERT: rd_byte = invert_regs[cmd_q[2:0]];
				iox_pkg::GRP_DIR: rd_byte = direction_regs[cmd_q[2:0]];
				iox_pkg::GRP_MASK: rd_byte = alert_mask_regs[cmd_q[2:0]];
				default: rd_byte = 8'h00;
			endcase
		end
	end

	// ============================================================
	// pin drivers
	logic [iox_pkg::PIN_COUNT-1:0] io_oe_q;

	// output enable registered so pins never glitch on decode
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			io_oe_q <= '0;
		end else if (oe_n_s) begin
			io_oe_q <= '0;
		end else begin
			io_oe_q <= ~dir_flat;
		end
	end

	assign IO_O = drive_flat;
	assign IO_OE = io_oe_q;

	// ============================================================
	// change alert
	logic [iox_pkg::PIN_COUNT-1:0] prev_q; // last seen pin levels
	logic [iox_pkg::PIN_COUNT-1:0] pend_q; // changes not yet read
	logic [iox_pkg::PIN_COUNT-1:0] chg;
	logic [iox_pkg::PIN_COUNT-1:0] clr;
	logic prime_q; // prev_q holds real levels

	// a read of a level bank clears its pending bits; without prime_q
	// every high pin would look like a change just after reset
	assign chg = prime_q ? ((io_s ^ prev_q) & dir_flat & ~mask_flat) : '0;
	assign clr = (rd_load && cmd_q[5:3] == iox_pkg::GRP_LEVEL &&
		bank_ok(cmd_q[5:0])) ?
		({{(iox_pkg::PIN_COUNT-8){1'b0}}, 8'hFF} << {cmd_q[2:0], 3'h0}) : '0;

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			prev_q <= '0;
			pend_q <= '0;
			prime_q <= 1'b0;
		end else if (rst_pin_s) begin
			pend_q <= '0;
			prime_q <= 1'b0;
		end else begin
			prev_q <= io_s;
			prime_q <= 1'b1;
			pend_q <= (pend_q & ~clr) | chg;
		end
	end

	assign INT_O = 1'b0;
	assign INT_OE = |(pend_q & ~mask_flat);

	// ============================================================
	// assertions
	a_addr_match: assert property (@(posedge CLK) disable iff (!ARST_N)
		(state_q == iox_pkg::ST_AACK) |-> (shift_q[7:1] == own_addr))
		else $error("acknowledged a foreign address");

	a_cmd_store: assert property (@(posedge CLK) disable iff (!ARST_N)
		(cmd_load && !rst_pin_s) |=> (cmd_q == $past(shift_q)))
		else $error("command byte not stored");

	a_step_wrap: assert property (@(posedge CLK) disable iff (!ARST_N)
		(step && !rst_pin_s && cmd_q[2:0] == 3'h4) |=> (cmd_q[2:0] == 3'h0))
		else $error("pointer did not wrap after last bank");

	a_step_next: assert property (@(posedge CLK) disable iff (!ARST_N)
		(step && !rst_pin_s && cmd_q[2:0] < 3'h4) |=>
		(cmd_q[2:0] == $past(cmd_q[2:0]) + 3'h1) && $stable(cmd_q[5:3]))
		else $error("pointer did not advance by one");

	a_fixed_hold: assert property (@(posedge CLK) disable iff (!ARST_N)
		((wr_evt || rd_done) && !cmd_q[7] && !rst_pin_s) |=> $stable(cmd_q))
		else $error("pointer moved with step flag clear");

	a_nack_level: assert property (@(posedge CLK) disable iff (!ARST_N)
		(state_q == iox_pkg::ST_WACK && cmd_q[5:3] == iox_pkg::GRP_LEVEL)
		|-> !sda_oe_q)
		else $error("write to level register acknowledged");

	a_out_at_ack: assert property (@(posedge CLK) disable iff (!ARST_N)
		(wr_evt && !rst_pin_s && cmd_q[5:0] == 6'h08) |=>
		(IO_O[7:0] == $past(shift_q)) && sda_oe_q)
		else $error("bank zero output not updated at acknowledge");

	a_invert_read: assert property (@(posedge CLK) disable iff (!ARST_N)
		(rd_load && !bus_start && !bus_stop && !rst_pin_s &&
		cmd_q[5:0] == 6'h00) |=>
		(shift_q == $past(io_s[7:0] ^ invert_regs[0])))
		else $error("level read not inverted per polarity");

	a_oe_float: assert property (@(posedge CLK) disable iff (!ARST_N)
		oe_n_s |=> (IO_OE == '0))
		else $error("outputs driven while drive enable high");

	a_reset_inputs: assert property (@(posedge CLK) disable iff (!ARST_N)
		rst_pin_s |=> ##1 (IO_OE == '0) && (cmd_q == iox_pkg::CMD_RESET))
		else $error("reset did not return pins to inputs");

	a_alert_raise: assert property (@(posedge CLK) disable iff (!ARST_N)
		(chg != '0 && !rst_pin_s) |=> (INT_OE || $changed(mask_flat)))
		else $error("unmasked input change did not raise alert");
endmodule

`default_nettype wire

/* iox_pkg.sv */
// Purpose: shared constants and types for the forty-pin serial-bus expander
// Assumes: five banks of eight pins, six-bit register pointer
// Notes: pointer groups sit at multiples of eight; positions 5..7 are holes

// ============================================================
// package
package iox_pkg;
	// pin organisation
	localparam int BANK_W = 8;
	localparam int NUM_BANKS = 5;
	localparam int PIN_COUNT = NUM_BANKS * BANK_W;
	localparam int PTR_W = 6;
	// synchronised inputs: pins, scl, sda, three selects, oe, reset
	localparam int SYNC_W = PIN_COUNT + 7;

	// command register layout and reset value
	localparam int STEP_BIT = 7;
	localparam logic [7:0] CMD_RESET = 8'h80;
	localparam logic [2:0] LAST_BANK = 3'h4;

	// register group codes (pointer bits 5..3)
	localparam logic [2:0] GRP_LEVEL = 3'h0;
	localparam logic [2:0] GRP_DRIVE = 3'h1;
	localparam logic [2:0] GRP_INVERT = 3'h2;
	localparam logic [2:0] GRP_DIR = 3'h3;
	localparam logic [2:0] GRP_MASK = 3'h4;

	// per-bank reset values; direction one means input
	localparam logic [7:0] DRIVE_RESET = 8'h00;
	localparam logic [7:0] INVERT_RESET = 8'h00;
	localparam logic [7:0] DIR_RESET = 8'hFF;
	localparam logic [7:0] MASK_RESET = 8'h00;

	// bus clock rates served (standard and fast) and the core clock rate
	localparam int SCL_STD_HZ = 100_000;
	localparam int SCL_FAST_HZ = 400_000;
	localparam int CLK_HZ = 50_000_000;

	// bus target states
	typedef enum logic [3:0] {
		ST_IDLE,
		ST_ADDR,
		ST_AACK,
		ST_CMD,
		ST_CACK,
		ST_WDATA,
		ST_WACK,
		ST_RDATA,
		ST_RACK,
		ST_WAIT
	} iox_state_t;
endpackage

/* iox_sync.sv */
// Purpose: two-flop synchroniser for a bundle of asynchronous inputs
// Assumes: each bit is independent; no multi-bit coherency needed
// Notes: reset value per bit comes from INIT; the top starts its reset pin asserted

`timescale 1ns/10ps
`default_nettype none

// ============================================================
// synchroniser
module iox_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic CLK,
	input wire logic ARST_N,
	input wire logic [W-1:0] D,
	output logic [W-1:0] Q
);
	logic [W-1:0] meta_q; // first stage, read only by the second

	// two stages, nothing looks at the first one
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			meta_q <= INIT;
			Q <= INIT;
		end else begin
			meta_q <= D;
			Q <= meta_q;
		end
	end
endmodule

`default_nettype wire

/* iox_master.sv */
// Purpose: behavioural serial-bus master facing the expander's bus pins
// Assumes: bench clock at 50 MHz; one bus bit lasts eight clock cycles
// Notes: clock stands high between frames; data line is pulled up

`timescale 1ns/10ps
`default_nettype none

// ============================================================
// bus master model
module iox_master (
	input wire logic clk,
	input wire logic sda_in,
	output var logic scl_o,
	output var logic sda_pull
);
	// both lines released while idle
	initial begin
		scl_o = 1'b1;
		sda_pull = 1'b0;
	end

	// one bit: five cycles low, three high, 160 ns in all
	// data moves mid-low so the target never sees it move with clock high
	task automatic bit_cycle(input logic b, output logic r);
		repeat (2) @(posedge clk);
		sda_pull <= ~b;
		repeat (3) @(posedge clk);
		scl_o <= 1'b1;
		repeat (3) @(posedge clk);
		r = sda_in;
		scl_o <= 1'b0;
	endtask

	// start or repeated start: data falls while the clock is high
	task automatic start();
		repeat (2) @(posedge clk);
		sda_pull <= 1'b0;
		repeat (4) @(posedge clk);
		scl_o <= 1'b1;
		repeat (4) @(posedge clk);
		sda_pull <= 1'b1;
		repeat (4) @(posedge clk);
		scl_o <= 1'b0;
	endtask

	// stop: data rises while the clock is high, then the bus rests
	task automatic stop();
		repeat (2) @(posedge clk);
		sda_pull <= 1'b1;
		repeat (3) @(posedge clk);
		scl_o <= 1'b1;
		repeat (4) @(posedge clk);
		sda_pull <= 1'b0;
		repeat (8) @(posedge clk);
	endtask

	// byte out, msb first; ack means the target pulled the line low
	task automatic send(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_cycle(d[i], r);
		end
		bit_cycle(1'b1, r);
		ack = ~r;
	endtask

	// byte in; the last byte of a read is answered with no acknowledge
	task automatic recv(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_cycle(1'b1, r);
			d[i] = r;
		end
		bit_cycle(last, r);
	endtask
endmodule

`default_nettype wire

/* test_iox_top.sv */
// Purpose: self-checking bench for the forty-pin expander top
// Assumes: master model timing; pin levels resolved in this module
// Notes: a driven pin shows the device value, a floating one the bench

`timescale 1ns/10ps
`default_nettype none

`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin \
	fails++; $display("MISMATCH %0t got %h exp %h", $time, (g), (e)); \
	end end

// ============================================================
// bench top
module test_iox_top;
	localparam logic [3:0] PFX = 4'h4; // fixed upper address bits
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic rst_pin_n = 1'b1;
	logic drv_en_n = 1'b0;
	logic [2:0] sel = 3'h5; // strapped select
	logic [39:0] ext = 40'h12_3456_789a; // outside level of floating pins
	logic scl, m_pull, sda_o, sda_oe, int_o, int_oe;
	logic [39:0] io_o, io_oe;
	wire logic sda;
	wire logic [39:0] io_i;
	int fails = 0;
	int tests_run = 0;
	logic [5:0] ak; // data acknowledges of the last write
	logic [47:0] q; // bytes of the last read, first byte lowest

	always #10 clk = ~clk;
	// open-drain data line with pull-up; the device drives its data level
	assign sda = ~m_pull & (sda_oe ? sda_o : 1'b1);
	assign io_i = (io_oe & io_o) | (~io_oe & ext);

	iox_top #(.ADDR_PREFIX(PFX)) uut (.CLK(clk), .ARST_N(arst_n),
		.RESET_N(rst_pin_n), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o),
		.SDA_OE(sda_oe), .ADDR_SELECT_0(sel[0]), .ADDR_SELECT_1(sel[1]),
		.ADDR_SELECT_2(sel[2]), .DRIVE_EN_N(drv_en_n), .IO_I(io_i),
		.IO_O(io_o), .IO_OE(io_oe), .INT_O(int_o), .INT_OE(int_oe));
	iox_master m (.clk(clk), .sda_in(sda), .scl_o(scl), .sda_pull(m_pull));

	// ============================================================
	// bus transfers
	// write: command, then n data bytes; acks collected in ak
	task automatic wr(input logic [7:0] cmd, input logic [47:0] d,
		input int n);
		logic x;
		ak = '0;
		m.start();
		m.send({PFX, sel, 1'b0}, x);
		m.send(cmd, x);
		for (int i = 0; i < n; i++) begin
			m.send(d[8*i+:8], x);
			ak[i] = x;
		end
		m.stop();
	endtask
	// read n bytes, optionally after loading the command first
	task automatic rd(input logic [7:0] cmd, input logic setp, input int n);
		logic x;
		logic [7:0] b;
		q = '0;
		if (setp) begin
			m.start();
			m.send({PFX, sel, 1'b0}, x);
			m.send(cmd, x);
		end
		m.start();
		m.send({PFX, sel, 1'b1}, x);
		for (int i = 0; i < n; i++) begin
			m.recv(i == n - 1, b);
			q[8*i+:8] = b;
		end
		m.stop();
	endtask

	// ============================================================
	// scenarios
	task automatic t_power();
		`CHK(io_oe, 40'h00_0000_0000)
		rd(8'h00, 1'b0, 2);
		`CHK(q[15:0], 16'h789a)
	endtask
	task automatic t_addr();
		logic x;
		m.start();
		m.send({PFX, 3'h2, 1'b0}, x);
		m.stop();
		`CHK(x, 1'b0)
		@(posedge clk) sel <= 3'h2;
		repeat (4) @(posedge clk);
		wr(8'h0a, 48'h77, 1);
		`CHK(io_o[23:16], 8'h77)
		@(posedge clk) sel <= 3'h5;
		repeat (4) @(posedge clk);
	endtask
	task automatic t_out();
		wr(8'h98, 48'h0, 5);
		`CHK(ak[4:0], 5'h1f)
		`CHK(io_oe, 40'hff_ffff_ffff)
		// six bytes: the sixth wraps onto bank 0
		wr(8'h88, 48'h6655_4433_2211, 6);
		`CHK(ak, 6'h3f)
		`CHK(io_o, 40'h55_4433_2266)
	endtask
	task automatic t_fixed();
		wr(8'h0a, 48'h03_0201, 3);
		`CHK(io_o[31:16], 16'h4403)
		rd(8'h0a, 1'b1, 2);
		`CHK(q[15:0], 16'h0303)
	endtask
	task automatic t_level();
		wr(8'h01, 48'h5a, 1);
		`CHK(ak[0], 1'b0)
		rd(8'h80, 1'b1, 2);
		`CHK(q[15:0], 16'h2266)
	endtask
	task automatic t_invert();
		wr(8'h10, 48'hff, 1);
		rd(8'h00, 1'b1, 1);
		`CHK(q[7:0], 8'h99)
		rd(8'h01, 1'b1, 1);
		`CHK(q[7:0], 8'h22)
		wr(8'h10, 48'h00, 1);
	endtask
	task automatic t_drive();
		@(posedge clk) drv_en_n <= 1'b1;
		repeat (6) @(posedge clk);
		`CHK(io_oe, 40'h00_0000_0000)
		@(posedge clk) drv_en_n <= 1'b0;
		repeat (6) @(posedge clk);
		`CHK(io_oe, 40'hff_ffff_ffff)
	endtask
	task automatic t_alert();
		wr(8'h19, 48'hff, 1);
		wr(8'h21, 48'h01, 1);
		rd(8'h01, 1'b1, 1);
		`CHK(q[7:0], 8'h78)
		`CHK(int_oe, 1'b0)
		// masked pin first, then an open one
		@(posedge clk) ext[8] <= 1'b1;
		repeat (8) @(posedge clk);
		`CHK(int_oe, 1'b0)
		@(posedge clk) ext[9] <= 1'b1;
		repeat (8) @(posedge clk);
		`CHK(int_oe, 1'b1)
		`CHK(int_o, 1'b0)
		rd(8'h01, 1'b1, 1);
		`CHK(q[7:0], 8'h7b)
		`CHK(int_oe, 1'b0)
	endtask
	task automatic t_pin_reset();
		@(posedge clk) rst_pin_n <= 1'b0;
		repeat (6) @(posedge clk);
		`CHK(io_oe, 40'h00_0000_0000)
		@(posedge clk) rst_pin_n <= 1'b1;
		repeat (8) @(posedge clk);
		rd(8'h00, 1'b0, 1);
		`CHK(q[7:0], 8'h9a)
		rd(8'h18, 1'b1, 1);
		`CHK(q[7:0], 8'hff)
	endtask

	// ============================================================
	// verdict and end of run
	task automatic stop_test();
		if (fails == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// main sequence: reset for four cycles, then the scenarios
	initial begin
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		repeat (20) @(posedge clk);
		t_power();
		t_addr();
		t_out();
		t_fixed();
		t_level();
		t_invert();
		t_drive();
		t_alert();
		t_pin_reset();
		stop_test();
	end

	// watchdog: the scenarios need well under half of this span
	initial begin
		#1_000_000;
		fails++;
		stop_test();
	end
endmodule

`default_nettype wire
